// ===== sob_top.sv
`timescale 1ns/1ps
module sob_top #(
	parameter logic [sob_pkg::CNT_W-1:0] WINDOW_CYC = sob_pkg::CNT_W'(sob_pkg::FBK_WINDOW_CYC),
	parameter logic [sob_pkg::CNT_W-1:0] FLASH_CYC  = sob_pkg::CNT_W'(sob_pkg::FLASH_HALF_CYC)
) (
	input  wire logic                                      clk,
	input  wire logic                                      rst,
	input  wire logic [1:0]                                group_mode,
	input  wire logic                                      high_current_variant,
	input  wire sob_pkg::sob_cfg_s [sob_pkg::NUM_CH-1:0]   cfg,
	input  wire logic [sob_pkg::NUM_CH-1:0]                logic_in,
	input  wire logic [sob_pkg::NUM_CH-1:0]                restart_feedback_input,
	input  wire logic                                      master_reset_operator,
	output logic [sob_pkg::NUM_CH-1:0]                     safety_switching_output,
	output logic [sob_pkg::NUM_CH-1:0]                     status_export,
	output logic [sob_pkg::NUM_CH-1:0]                     error_output,
	output logic [sob_pkg::NUM_CH-1:0]                     clear_indicator,
	output logic [sob_pkg::NUM_CH-1:0]                     restart_input_present
);

	// ----------------------------------------
	// Group decoding
	// ----------------------------------------
	function automatic logic block_used(input logic [1:0] mode, input int unsigned b);
		logic used;
		case (mode)
			sob_pkg::GRP_TWO_DOUBLE: used = (b == 0) || (b == 2);
			sob_pkg::GRP_MIXED:      used = (b != 3);
			default:                 used = 1'b1;
		endcase
		return used;
	endfunction : block_used

	function automatic logic [1:0] ch_owner(input logic [1:0] mode, input logic [1:0] ch);
		logic [1:0] owner;
		case (mode)
			sob_pkg::GRP_TWO_DOUBLE: owner = {ch[1], 1'b0};
			sob_pkg::GRP_MIXED:      owner = ch[1] ? 2'h2 : ch;
			default:                 owner = ch;
		endcase
		return owner;
	endfunction : ch_owner

	// ----------------------------------------
	// Output blocks
	// ----------------------------------------
	logic [sob_pkg::NUM_CH-1:0] blk_on;
	logic [sob_pkg::NUM_CH-1:0] blk_stat;
	logic [sob_pkg::NUM_CH-1:0] blk_err;
	logic [sob_pkg::NUM_CH-1:0] blk_fault;
	logic [sob_pkg::NUM_CH-1:0] blk_used;

	genvar gi;
	generate
		for (gi = 0; gi < sob_pkg::NUM_CH; gi++)
		begin : g_blk
			assign blk_used[gi] = block_used(group_mode, gi);
			sob_chan #(
				.WINDOW_CYC   (WINDOW_CYC)
			) u_chan (
				.clk          (clk),
				.rst          (rst),
				.cfg          (cfg[gi]),
				.logic_in     (logic_in[gi] & blk_used[gi]),
				.rfb_in       (restart_feedback_input[gi]),
				.master_reset (master_reset_operator),
				.out_on       (blk_on[gi]),
				.status_on    (blk_stat[gi]),
				.error_on     (blk_err[gi]),
				.fault_on     (blk_fault[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	sob_pkg::sob_top_s r;
	sob_pkg::sob_top_s n;

	always_comb
	begin
		n = r;
		// Flash rate enable
		if (r.flash_cnt >= FLASH_CYC - sob_pkg::CNT_W'(1))
		begin
			n.flash_cnt = '0;
			n.phase     = ~r.phase;
		end
		else
			n.flash_cnt = r.flash_cnt + sob_pkg::CNT_W'(1);
		for (int c = 0; c < sob_pkg::NUM_CH; c++)
		begin
			// Output and indicator of both channels of a double block follow the one owner
			n.out[c] = blk_on[ch_owner(group_mode, 2'(c))];
			n.led[c] = blk_fault[ch_owner(group_mode, 2'(c))] & r.phase;
			n.stat[c] = blk_used[c] & blk_stat[c];
			n.err[c] = blk_used[c] & blk_err[c];
			n.present[c] = blk_used[c] & (high_current_variant
				| cfg[c].reset_req | cfg[c].edm_en);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= sob_pkg::TOP_RST;
		else
			r <= n;
	end

	assign safety_switching_output = r.out;
	assign status_export           = r.stat;
	assign error_output            = r.err;
	assign clear_indicator         = r.led;
	assign restart_input_present   = r.present;

endmodule : sob_top

// ===== sob_pkg.sv
// Notes on behaviour
// - Dual-channel output drives both channels on while logic input is 1, else off.
// - Each output pair has one combined restart and feedback input.
// - Reset option holds output off after each input fall until valid reset.
// - Manual reset accepts one 0 to 1 transition on restart input.
// - Monitored reset needs 0 to 1 then back to 0 on restart input.
// - Status option exports current output state to the logic scheme.
// - Feedback must be complement of output within window after each change.
// - Missed feedback forces output low and flashes its clear indicator.
// - Error option drives error output high on feedback fault.
// - Error output stays latched until power cycle or master reset operator.
// - Single-channel output drives its channel on while input is 1, else off.
// - Restart input present only with reset or check, except high-current variant.
// - Four channels form four single, two double, or two single plus one double.
package sob_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned CNT_W          = 24;
	localparam int unsigned FBK_WINDOW_MS  = 100;
	localparam int unsigned FBK_WINDOW_CYC = FBK_WINDOW_MS * CYC_PER_MS;
	localparam int unsigned FLASH_HALF_MS  = 250;
	localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;

	// ----------------------------------------
	// Channel group
	// ----------------------------------------
	localparam int unsigned NUM_CH          = 4;
	localparam logic [1:0]  GRP_FOUR_SINGLE = 2'h0;
	localparam logic [1:0]  GRP_TWO_DOUBLE  = 2'h1;
	localparam logic [1:0]  GRP_MIXED       = 2'h2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic reset_req;
		logic monitored;
		logic edm_en;
		logic status_en;
		logic err_en;
	} sob_cfg_s;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_ARM,
		ST_PULSE,
		ST_ON
	} sob_chan_st_e;

	typedef struct packed {
		sob_chan_st_e     st;
		logic [CNT_W-1:0] cnt;
		logic             rfb_d;
		logic             out_d;
		logic             fault;
		logic             err;
	} sob_chan_s;

	typedef struct packed {
		logic [NUM_CH-1:0] out;
		logic [NUM_CH-1:0] stat;
		logic [NUM_CH-1:0] err;
		logic [NUM_CH-1:0] led;
		logic [NUM_CH-1:0] present;
		logic [CNT_W-1:0]  flash_cnt;
		logic              phase;
	} sob_top_s;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam sob_chan_s CHAN_RST = '{st: ST_OFF, cnt: '0, rfb_d: 1'b0, out_d: 1'b0,
		fault: 1'b0, err: 1'b0};
	localparam sob_top_s  TOP_RST  = '0;

endpackage : sob_pkg

// ===== sob_chan.sv
`timescale 1ns/1ps
module sob_chan #(
	parameter logic [sob_pkg::CNT_W-1:0] WINDOW_CYC = sob_pkg::CNT_W'(sob_pkg::FBK_WINDOW_CYC)
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire sob_pkg::sob_cfg_s cfg,
	input  wire logic              logic_in,
	input  wire logic              rfb_in,
	input  wire logic              master_reset,
	output logic                   out_on,
	output logic                   status_on,
	output logic                   error_on,
	output logic                   fault_on
);

	sob_pkg::sob_chan_s r;
	sob_pkg::sob_chan_s n;
	logic               rise;
	logic               fall;
	logic               now_on;
	logic               check;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		n      = r;
		rise   = rfb_in & ~r.rfb_d;
		fall   = ~rfb_in & r.rfb_d;
		now_on = (r.st == sob_pkg::ST_ON);
		n.rfb_d = rfb_in;
		n.out_d = now_on;
		case (r.st)
			sob_pkg::ST_OFF:
			begin
				if (logic_in)
					n.st = cfg.reset_req ? sob_pkg::ST_ARM : sob_pkg::ST_ON;
			end
			sob_pkg::ST_ARM:
			begin
				if (rise)
					n.st = cfg.monitored ? sob_pkg::ST_PULSE : sob_pkg::ST_ON;
			end
			sob_pkg::ST_PULSE:
			begin
				if (fall)
					n.st = sob_pkg::ST_ON;
			end
			sob_pkg::ST_ON:
			begin
				n.st = sob_pkg::ST_ON;
			end
			default:
			begin
				n.st = sob_pkg::ST_OFF;
			end
		endcase
		if (!logic_in || r.fault)
			n.st = sob_pkg::ST_OFF;
		// Window restarts on every output change
		if (now_on != r.out_d)
			n.cnt = WINDOW_CYC;
		else if (r.cnt != '0)
			n.cnt = r.cnt - sob_pkg::CNT_W'(1);
		// While armed the restart edge stands for the released contactors
		check = cfg.edm_en && (r.cnt == '0) && (now_on == r.out_d)
			&& (now_on || !cfg.reset_req || r.st == sob_pkg::ST_OFF);
		if (master_reset)
		begin
			n.fault = 1'b0;
			n.err   = 1'b0;
		end
		if (check && (rfb_in == now_on))
		begin
			n.fault = 1'b1;
			if (cfg.err_en)
				n.err = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			r <= sob_pkg::CHAN_RST;
		else
			r <= n;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign out_on    = (r.st == sob_pkg::ST_ON);
	assign status_on = cfg.status_en & out_on;
	assign error_on  = cfg.err_en & r.err;
	assign fault_on  = r.fault;

endmodule : sob_chan

// ===== sob_top_properties.sv
`timescale 1ns/1ps
module sob_top_properties #(
	parameter logic [sob_pkg::CNT_W-1:0] WINDOW_CYC = '0,
	parameter logic [sob_pkg::CNT_W-1:0] FLASH_CYC  = '0
) (
	input wire logic                                    clk,
	input wire logic                                    rst,
	input wire logic [1:0]                              group_mode,
	input wire logic                                    high_current_variant,
	input wire sob_pkg::sob_cfg_s [sob_pkg::NUM_CH-1:0] cfg,
	input wire logic [sob_pkg::NUM_CH-1:0]              logic_in,
	input wire logic [sob_pkg::NUM_CH-1:0]              restart_feedback_input,
	input wire logic                                    master_reset_operator,
	input wire logic [sob_pkg::NUM_CH-1:0]              safety_switching_output,
	input wire logic [sob_pkg::NUM_CH-1:0]              status_export,
	input wire logic [sob_pkg::NUM_CH-1:0]              error_output,
	input wire logic [sob_pkg::NUM_CH-1:0]              clear_indicator,
	input wire logic [sob_pkg::NUM_CH-1:0]              restart_input_present
);
	// ----
	// Block 0 checks
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire               g0 = group_mode == 2'h0;
	wire               hc = high_current_variant;
	wire sob_pkg::sob_cfg_s c = cfg[0];
	wire [3:0]         o = safety_switching_output;
	wire [3:0]         r = restart_feedback_input;
	wire [3:0]         e = error_output;
	a_follow_on: assert property (g0 && !c.reset_req && !c.edm_en && $rose(logic_in[0])
		|-> ##2 o[0]) else $error("output did not follow input");
	a_follow_off: assert property (g0 && $fell(logic_in[0]) |-> ##2 !o[0])
		else $error("output did not drop");
	a_manual_edge: assert property (g0 && c.reset_req && !c.monitored && $rose(o[0])
		|-> $past(r[0], 2) && !$past(r[0], 3)) else $error("on without rising restart");
	a_monitor_pulse: assert property (g0 && c.reset_req && c.monitored && $rose(o[0])
		|-> $past(r[0], 3) && !$past(r[0], 2)) else $error("on without full pulse");
	a_double_pair: assert property (group_mode == 2'h1 && $past(group_mode) == 2'h1 && !$past(rst)
		|-> o[1] == o[0]) else $error("pair split");
	a_status_gate: assert property (!c.status_en |-> !status_export[0])
		else $error("status without option");
	a_err_gate: assert property (!c.err_en |-> !e[0]) else $error("error without option");
	a_err_hold: assert property (e[0] && !$past(master_reset_operator)
		&& !master_reset_operator |=> e[0]) else $error("error not latched");
	a_fault_off: assert property (e[0] && $past(e[0]) |-> !o[0]) else $error("on in fault");
	a_no_check_led: assert property (!c.edm_en |-> !clear_indicator[0])
		else $error("indicator without check");
	a_present_hc: assert property (g0 && $past(g0) && $past(hc) && !$past(rst)
		|-> restart_input_present[0]) else $error("restart input missing");
endmodule : sob_top_properties

// ===== sob_contactor.sv
`timescale 1ns/1ps
module sob_contactor (
	input  wire logic       clk,
	input  wire logic       slow,
	input  wire logic [3:0] out,
	input  wire logic [3:0] press,
	input  wire logic [3:0] weld,
	output logic      [3:0] rfb
);
	// ----
	// Contactor lag
	// ----
	logic [3:0] k1_r;
	logic [3:0] k2_r;
	always_ff @(posedge clk)
	begin
		k1_r <= out;
		k2_r <= k1_r;
	end
	// Button in series with the closed-when-released contact; a weld holds it open
	assign rfb = press & ~(weld | (slow ? k2_r : k1_r));
endmodule : sob_contactor

// ===== sob_top_tb_top.sv
`timescale 1ns/1ps
module sob_top_tb_top;
	// ----
	// Bench
	// ----
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	logic [1:0]              gm = 2'h0;
	logic                    hcv = 1'b0;
	sob_pkg::sob_cfg_s [3:0] cfg = '0;
	logic [3:0]              li = 4'h0;
	logic [3:0]              press = 4'hf;
	logic [3:0]              weld = 4'h0;
	logic                    slow = 1'b0;
	logic                    mr = 1'b0;
	wire  [3:0]              rfb, o, st, e, ci, pr;
	logic [3:0]              o_s, st_s, e_s, ci_s, pr_s;
	int                      fails = 0;
	int                      total_checks = 0;
	int                      n;
	int                      k;
	logic                    p;
	always #10 clk = ~clk;
	// Outputs taken mid-cycle, where they have settled
	always @(negedge clk)
		{o_s, st_s, e_s, ci_s, pr_s} <= {o, st, e, ci, pr};
	sob_top #(.WINDOW_CYC(24'h14), .FLASH_CYC(24'h4)) DUT (.clk, .rst, .group_mode(gm),
		.high_current_variant(hcv), .cfg, .logic_in(li), .restart_feedback_input(rfb),
		.master_reset_operator(mr), .safety_switching_output(o), .status_export(st),
		.error_output(e), .clear_indicator(ci), .restart_input_present(pr));
	sob_contactor u_k (.clk, .slow, .out(o), .press, .weld, .rfb);
	task automatic tick(input int t);
		repeat (t) @(posedge clk);
	endtask : tick
	task automatic chk(input string s, input logic [3:0] x, input logic [3:0] y);
		total_checks++;
		if (y !== x)
		begin
			fails++;
			$display("unexpected %s: expected %h seen %h", s, x, y);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic do_reset();
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(1);
	endtask : do_reset
	function automatic logic [3:0] used(input logic [1:0] g);
		return (g == 2'h1) ? 4'h5 : (g == 2'h2) ? 4'h7 : 4'hf;
	endfunction : used
	function automatic logic [3:0] pins(input logic [1:0] g, input logic [3:0] l);
		return (g == 2'h1) ? {{2{l[2]}}, {2{l[0]}}} : (g == 2'h2) ? {{2{l[2]}}, l[1:0]} : l;
	endfunction : pins
	task automatic rst_test(input logic m);
		cfg[0] <= {1'b1, m, 3'h0};
		gm <= 2'h0;
		hcv <= 1'b0;
		press <= 4'h0;
		li <= 4'h0;
		do_reset();
		li <= 4'h1;
		tick(3);
		chk("present", 4'h1, pr_s);
		chk("held", 4'h0, o_s);
		press <= 4'h1;
		tick(3);
		chk("manual", {3'h0, !m}, o_s);
		press <= 4'h0;
		tick(3);
		chk("pulse", 4'h1, o_s);
		li <= 4'h0;
		tick(3);
		li <= 4'h1;
		tick(3);
		chk("rearm", 4'h0, o_s);
	endtask : rst_test
	initial
	begin
		void'($urandom(97987));
		cfg <= {4{5'h02}};
		do_reset();
		for (int i = 0; i < 24; i++)
		begin
			gm <= 2'($urandom);
			li <= (i == 0) ? 4'h5 : 4'($urandom);
			hcv <= 1'($urandom);
			tick(3);
			chk("out", pins(gm, li), o_s);
			chk("status", li & used(gm), st_s);
			chk("present", hcv ? used(gm) : 4'h0, pr_s);
		end
		rst_test(1'b0);
		rst_test(1'b1);
		cfg[0] <= 5'h07;
		press <= 4'hf;
		slow <= 1'($urandom);
		do_reset();
		tick(30);
		chk("checked on", 4'h1, o_s);
		chk("no error", 4'h0, e_s);
		weld <= 4'h1;
		li <= 4'h0;
		tick(24);
		chk("early error", 4'h0, e_s);
		for (n = 0; n < 40 && e_s[0] !== 1'b1; n++)
			tick(1);
		if (n == 40)
			chk("error wait", 4'h1, e_s);
		else
		begin
			chk("error delay", 4'h1, 4'(n));
			chk("error", 4'h1, e_s);
			k = 0;
			for (int i = 0; i < 12; i++)
			begin
				p = ci_s[0];
				tick(1);
				k += int'(ci_s[0] !== p);
			end
			chk("flash", 4'h3, 4'(k));
			li <= 4'h1;
			tick(5);
			chk("forced off", 4'h0, o_s);
			chk("latched", 4'h1, e_s);
			weld <= 4'h0;
			li <= 4'h0;
			mr <= 1'b1;
			tick(1);
			mr <= 1'b0;
			tick(3);
			chk("cleared", 4'h0, e_s);
		end
		wrap_up();
	end
endmodule : sob_top_tb_top
bind sob_top sob_top_properties #(.WINDOW_CYC(WINDOW_CYC), .FLASH_CYC(FLASH_CYC)) u_chk (.clk,
	.rst, .group_mode, .high_current_variant, .cfg, .logic_in, .restart_feedback_input,
	.master_reset_operator, .safety_switching_output, .status_export, .error_output,
	.clear_indicator, .restart_input_present);
